// *** hw/nvsc_host.sv ***
// host-side controller for a 32K x 8 nvsram on an asynchronous bus
// assumes device pins are wired directly; store_busy_n has a pull-up
`default_nettype none
`include "nvsc_cfg.svh"

module nvsc_host #(
    parameter int STORE_CYC   = `NVSC_STORE_CYC,
    parameter int RECALL_CYC  = `NVSC_RECALL_CYC,
    parameter int RESTORE_CYC = `NVSC_RESTORE_CYC,
    parameter int SETUP_CYC   = 1,
    parameter int STRB_CYC    = 1
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               req_valid_i,
    input  wire nvsc_pkg::nvsc_op_type req_op_i,
    input  wire logic [14:0]        req_addr_i,
    input  wire logic [7:0]         req_wdata_i,
    output logic                    req_ready_o,
    output logic                    rsp_valid_o,
    output logic [7:0]              rsp_rdata_o,
    output logic                    hw_store_i_dummy_o,
    input  wire logic               hw_store_req_i,
    output logic [14:0]             address_lines_o,
    output logic [7:0]              data_lines_o,
    output logic                    data_lines_oe_n_o,
    input  wire logic [7:0]         data_lines_i,
    output logic                    chip_en_n_o,
    output logic                    out_en_n_o,
    output logic                    write_en_n_o,
    input  wire logic               store_busy_n_i,
    output logic                    store_busy_n_o,
    output logic                    store_busy_n_oe_n_o
);
    localparam int CW = 24;
    localparam int SWAIT = STORE_CYC + `NVSC_DELAY_CYC;
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    initial begin
        if (STORE_CYC < 1 || RECALL_CYC < 1 || RESTORE_CYC < 1 ||
            SETUP_CYC < 1 || STRB_CYC < 1 || SWAIT >= (1 << CW))
            $error("nvsc_host: timing parameters out of range");
    end

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // sequence address for step n of a store or recall
    function automatic logic [13:0] seq_addr(input logic [2:0] n,
                                             input logic rec);
        case (n)
            3'h0:    seq_addr = `NVSC_SEQ0;
            3'h1:    seq_addr = `NVSC_SEQ1;
            3'h2:    seq_addr = `NVSC_SEQ2;
            3'h3:    seq_addr = `NVSC_SEQ3;
            3'h4:    seq_addr = `NVSC_SEQ4;
            default: seq_addr = rec ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE;
        endcase
    endfunction
    function automatic logic [CW-1:0] to_cnt(input int v);
        to_cnt = CW'(v);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] dq_s1_q, dq_s2_q;
    logic       busy_s1_q, busy_s2_q;
    // two flops before any logic reads the device pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dq_s1_q   <= 8'h00;
            dq_s2_q   <= 8'h00;
            busy_s1_q <= 1'b1;
            busy_s2_q <= 1'b1;
        end else begin
            dq_s1_q   <= data_lines_i;
            dq_s2_q   <= dq_s1_q;
            busy_s1_q <= store_busy_n_i;
            busy_s2_q <= busy_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    nvsc_pkg::nvsc_state_type state_q;
    nvsc_pkg::nvsc_op_type    op_q;
    logic [CW-1:0]            cnt_q;
    logic [2:0]               step_q;
    logic [14:0]              addr_q;
    logic [7:0]               wdata_q;
    logic                     ce_n_q, we_n_q, drv_q, hsb_q, rsp_q, seq_op;
    logic [7:0]               rdata_q;
    assign seq_op      = op_q inside {nvsc_pkg::OP_STORE, nvsc_pkg::OP_RECALL};
    // no new request while busy is low or the nv cycle runs
    assign req_ready_o = state_q == nvsc_pkg::ST_IDLE && busy_s2_q;
    // main access state machine; waits restore time after reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= nvsc_pkg::ST_WAIT;
            cnt_q   <= to_cnt(RESTORE_CYC);
            op_q    <= nvsc_pkg::OP_READ;
            step_q  <= 3'h0;
            addr_q  <= 15'h0000;
            wdata_q <= 8'h00;
            ce_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            drv_q   <= 1'b0;
            hsb_q   <= 1'b0;
            rsp_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            rsp_q <= 1'b0;
            case (state_q)
                nvsc_pkg::ST_IDLE: begin
                    if (hw_store_req_i && busy_s2_q) begin
                        hsb_q   <= 1'b1;
                        cnt_q   <= to_cnt(SWAIT);
                        state_q <= nvsc_pkg::ST_HWST;
                    end else if (req_valid_i && busy_s2_q) begin
                        op_q    <= req_op_i;
                        wdata_q <= req_wdata_i;
                        step_q  <= 3'h0;
                        addr_q  <= (req_op_i == nvsc_pkg::OP_STORE ||
                                    req_op_i == nvsc_pkg::OP_RECALL) ?
                                   {1'b0, seq_addr(3'h0, 1'b0)} :
                                   req_addr_i;
                        cnt_q   <= to_cnt(SETUP_CYC);
                        state_q <= nvsc_pkg::ST_SETUP;
                    end
                end
                // address settles with strobes high before enable falls
                nvsc_pkg::ST_SETUP: begin
                    drv_q <= (op_q == nvsc_pkg::OP_WRITE);
                    if (cnt_q == to_cnt(1)) begin
                        ce_n_q  <= 1'b0;
                        we_n_q  <= !(op_q == nvsc_pkg::OP_WRITE);
                        cnt_q   <= to_cnt(STRB_CYC + 2);
                        state_q <= nvsc_pkg::ST_STRB;
                    end else begin
                        cnt_q <= cnt_q - to_cnt(1);
                    end
                end
                // strobe held long enough for synchronised read data
                nvsc_pkg::ST_STRB: begin
                    if (cnt_q == to_cnt(1)) begin
                        rdata_q <= dq_s2_q;
                        ce_n_q  <= 1'b1;
                        we_n_q  <= 1'b1;
                        state_q <= nvsc_pkg::ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q - to_cnt(1);
                    end
                end
                // data and address held one cycle past the rising edge
                nvsc_pkg::ST_HOLD: begin
                    drv_q <= 1'b0;
                    if (seq_op && step_q != 3'h5) begin
                        step_q  <= step_q + 3'h1;
                        addr_q  <= {1'b0, seq_addr(step_q + 3'h1,
                                    op_q == nvsc_pkg::OP_RECALL)};
                        cnt_q   <= to_cnt(SETUP_CYC);
                        state_q <= nvsc_pkg::ST_SETUP;
                    end else if (seq_op) begin
                        cnt_q   <= (op_q == nvsc_pkg::OP_STORE) ?
                                   to_cnt(STORE_CYC) :
                                   to_cnt(RECALL_CYC);
                        state_q <= nvsc_pkg::ST_WAIT;
                    end else begin
                        rsp_q   <= 1'b1;
                        state_q <= nvsc_pkg::ST_IDLE;
                    end
                end
                // nonvolatile cycle in progress: bus left quiet
                nvsc_pkg::ST_WAIT: begin
                    if (cnt_q <= to_cnt(1)) begin
                        rsp_q   <= 1'b1;
                        state_q <= nvsc_pkg::ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - to_cnt(1);
                    end
                end
                // pin store: a high pin means done only after the grace time
                nvsc_pkg::ST_HWST: begin
                    hsb_q <= 1'b0;
                    if (cnt_q <= to_cnt(1) || (!hsb_q && busy_s2_q &&
                        cnt_q < to_cnt(SWAIT - `NVSC_DELAY_CYC - 4))) begin
                        state_q <= nvsc_pkg::ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - to_cnt(1);
                    end
                end
                nvsc_pkg::ST_DONE: begin
                    if (busy_s2_q) begin
                        state_q <= nvsc_pkg::ST_IDLE;
                    end
                end
                default: state_q <= nvsc_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // oe stays high on writes and during sequence reads
    assign out_en_n_o          = !(state_q == nvsc_pkg::ST_STRB &&
                                   op_q == nvsc_pkg::OP_READ);
    assign address_lines_o     = addr_q;
    assign data_lines_o        = wdata_q;
    assign data_lines_oe_n_o   = !drv_q;
    assign chip_en_n_o         = ce_n_q;
    assign write_en_n_o        = we_n_q;
    assign store_busy_n_o      = 1'b0;
    assign store_busy_n_oe_n_o = !hsb_q;
    assign rsp_valid_o         = rsp_q;
    assign rsp_rdata_o         = rdata_q;
    assign hw_store_i_dummy_o  = busy_s2_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_oe_write;
        !write_en_n_o |-> out_en_n_o;
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("oe low in write");
    property p_seq_no_write;
        (seq_op && !chip_en_n_o) |-> write_en_n_o;
    endproperty
    a_seq_no_write: assert property (p_seq_no_write) else $error("seq write");
    property p_addr_stable;
        !chip_en_n_o |=> $stable(address_lines_o) || chip_en_n_o;
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("addr moved");
    property p_no_drive_read;
        !out_en_n_o |-> data_lines_oe_n_o;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("contend");
    property p_quiet_wait;
        (state_q == nvsc_pkg::ST_WAIT) |-> chip_en_n_o && write_en_n_o;
    endproperty
    a_quiet_wait: assert property (p_quiet_wait) else $error("access in nv");
    property p_busy_no_ready;
        (!busy_s2_q && state_q == nvsc_pkg::ST_IDLE) |=>
            state_q != nvsc_pkg::ST_SETUP;
    endproperty
    a_busy_no_ready: assert property (p_busy_no_ready) else $error("ready busy");
    property p_seq_addr;
        (seq_op && $fell(chip_en_n_o)) |->
            address_lines_o[13:0] == seq_addr(step_q,
                                     op_q == nvsc_pkg::OP_RECALL);
    endproperty
    a_seq_addr: assert property (p_seq_addr) else $error("bad seq addr");
    property p_step_adv;
        (seq_op && state_q == nvsc_pkg::ST_HOLD && step_q != 3'h5) |=>
            step_q == $past(step_q) + 3'h1;
    endproperty
    a_step_adv: assert property (p_step_adv) else $error("step skip");

    c_read:   cover property (@(posedge clk_i) rsp_valid_o &&
                              op_q == nvsc_pkg::OP_READ);
    c_write:  cover property (@(posedge clk_i) $rose(write_en_n_o));
    c_store:  cover property (@(posedge clk_i) state_q == nvsc_pkg::ST_WAIT
                              && op_q == nvsc_pkg::OP_STORE);
    c_hwst:   cover property (@(posedge clk_i) !store_busy_n_oe_n_o);
endmodule // nvsc_host
`default_nettype wire

// *** hw/nvsc_cfg.svh ***
// timing and sequence constants for the nvsram host controller
// assumes a 10 MHz clock driving the host logic
`ifndef NVSC_CFG_SVH
`define NVSC_CFG_SVH
`define NVSC_CLK_NS        100
`define NVSC_T_STORE_NS    10000000
`define NVSC_T_RECALL_NS   20000
`define NVSC_T_RESTORE_NS  550000
`define NVSC_T_DELAY_NS    1000
`define NVSC_STORE_CYC     ((`NVSC_T_STORE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_RECALL_CYC    ((`NVSC_T_RECALL_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_RESTORE_CYC   ((`NVSC_T_RESTORE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_DELAY_CYC     ((`NVSC_T_DELAY_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_SEQ0          14'h0E38
`define NVSC_SEQ1          14'h31C7
`define NVSC_SEQ2          14'h03E0
`define NVSC_SEQ3          14'h3C1F
`define NVSC_SEQ4          14'h303F
`define NVSC_SEQ_STORE     14'h0FC0
`define NVSC_SEQ_RECALL    14'h0C63
`endif

// *** hw/nvsc_pkg.sv ***
// types for the nvsram host controller
// assumes nvsc_cfg.svh is compiled alongside
`default_nettype none
package nvsc_pkg;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_SETUP = 7'h02,
        ST_STRB  = 7'h04,
        ST_HOLD  = 7'h08,
        ST_WAIT  = 7'h10,
        ST_HWST  = 7'h20,
        ST_DONE  = 7'h40
    } nvsc_state_type;
    typedef enum logic [1:0] {
        OP_READ   = 2'h0,
        OP_WRITE  = 2'h1,
        OP_STORE  = 2'h2,
        OP_RECALL = 2'h3
    } nvsc_op_type;
endpackage
`default_nettype wire

// *** dv/nvsc_dev_model.sv ***
// behavioural nvsram: array, shadow, store/recall sequence, busy pin
// assumes the bench resolves the busy line and the shared data lines
`default_nettype none
`include "nvsc_cfg.svh"
module nvsc_dev_model #(
    parameter int ST_CYC  = 40,
    parameter int RC_CYC  = 15,
    parameter int RS_CYC  = 15,
    parameter int DLY_CYC = 10
) (
    input  wire logic        clk_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [14:0] addr_i,
    input  wire logic [7:0]  bus_i,
    input  wire logic        busy_n_i,
    output var  logic        busy_pull_o,
    output var  logic [7:0]  dq_o,
    output var  int          store_cnt_o,
    output var  int          viol_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [13:0] SEQ [5] = '{`NVSC_SEQ0, `NVSC_SEQ1,
        `NVSC_SEQ2, `NVSC_SEQ3, `NVSC_SEQ4};
    logic [7:0]  mem [0:32767];
    logic [7:0]  nv  [0:32767];
    logic [7:0]  last_q  = 8'h00;
    logic [14:0] wr_addr = 15'h0000;
    logic        nvb     = 1'h1;
    logic        written = 1'h0;
    logic        wr_open = 1'h0;
    logic        wr_seen = 1'h0;
    int          step    = 0;
    event        go_st;
    event        go_rc;
    // ----------------------------------------
    // nonvolatile cycles
    // ----------------------------------------
    // power-up recall; the array is unusable until it lands
    initial begin
        busy_pull_o = 1'h0;
        for (int i = 0; i < 32768; i++) nv[i] = i[7:0] ^ 8'h5A;
        repeat (RS_CYC) @(posedge clk_i);
        mem = nv;
        nvb = 1'h0;
    end
    task automatic run_store();
        nvb = 1'h1;
        busy_pull_o = 1'h1;
        nv = '{default: 8'hFF};
        nv = mem;
        store_cnt_o++;
        written = 1'h0;
        repeat (ST_CYC) @(posedge clk_i);
        busy_pull_o = 1'h0;
        nvb = 1'h0;
    endtask
    always @(go_st) run_store();
    // recall clears first, shadow stays as it is
    always @(go_rc) begin
        nvb = 1'h1;
        mem = '{default: 8'h00};
        repeat (RC_CYC) @(posedge clk_i);
        mem = nv;
        written = 1'h0;
        nvb = 1'h0;
    end
    // pin store after the grace time, only with a write since; no supply
    // loss store here since the part sits in the inhibit wiring
    always @(negedge busy_n_i) begin
        if (!nvb) begin
            repeat (DLY_CYC) @(posedge clk_i);
            if (written) run_store();
        end
    end
    // read drive; outside a read the lines show a moving pattern
    always @* begin
        if (!ce_n_i && !oe_n_i && we_n_i && busy_n_i && !nvb)
            dq_o = mem[addr_i];
        else
            dq_o = ~last_q;
    end
    always @(posedge clk_i) last_q <= dq_o;
    // write opens with both strobes low and the busy line high
    always @(negedge ce_n_i or negedge we_n_i) begin
        if (!ce_n_i && !we_n_i) wr_seen = 1'h1;
        if (!ce_n_i && !we_n_i && busy_n_i && !nvb) begin
            wr_open = 1'h1;
            wr_addr = addr_i;
            if (!oe_n_i) viol_o++;
        end
    end
    // capture on whichever strobe ends the write
    always @(posedge ce_n_i or posedge we_n_i) begin
        if (wr_open) begin
            if (addr_i !== wr_addr) viol_o++;
            mem[wr_addr] = bus_i;
            written = 1'h1;
            wr_open = 1'h0;
        end
    end
    // detector steps per chip-enable rise, output enable not looked at
    always @(posedge ce_n_i) begin
        if (!nvb) begin
            if (wr_seen || !we_n_i) step = 0;
            else if (step == 5 && addr_i[13:0] == `NVSC_SEQ_STORE) begin
                step = 0;
                ->go_st;
            end else if (step == 5 && addr_i[13:0] == `NVSC_SEQ_RECALL) begin
                step = 0;
                ->go_rc;
            end else if (step < 5 && addr_i[13:0] == SEQ[step]) step++;
            else step = int'(addr_i[13:0] == SEQ[0]);
        end
        wr_seen = 1'h0;
    end
endmodule // nvsc_dev_model
`default_nettype wire

// *** dv/nvsc_host_tb.sv ***
// self-checking bench: host controller against the nvsram model
// assumes a pull-up on the busy line and no other bus parties
`default_nettype none
module nvsc_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DLY = 10;
    logic                  clk, rst_n, req_valid, hw_req, rdy, rsp;
    logic                  dq_oe_n, ce_n, oe_n, we_n, bsy_o, bsy_oe_n;
    logic                  pull, bsy, bsy_seen;
    nvsc_pkg::nvsc_op_type req_op;
    logic [14:0]           req_addr, addr;
    logic [7:0]            req_wdata, rdata, rsp_data, dq_host, dq_dev;
    logic [7:0]            dq_bus;
    int                    st_cnt, viol, n_fail, samples_checked, cyc;
    assign dq_bus = dq_oe_n ? dq_dev : dq_host;
    assign bsy = !(pull || (!bsy_oe_n && !bsy_o));
    nvsc_host #(.STORE_CYC(50), .RECALL_CYC(20), .RESTORE_CYC(20)) u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
        .req_op_i(req_op), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
        .req_ready_o(rdy), .rsp_valid_o(rsp), .rsp_rdata_o(rsp_data),
        .hw_store_i_dummy_o(bsy_seen), .hw_store_req_i(hw_req),
        .address_lines_o(addr), .data_lines_o(dq_host),
        .data_lines_oe_n_o(dq_oe_n), .data_lines_i(dq_bus),
        .chip_en_n_o(ce_n), .out_en_n_o(oe_n), .write_en_n_o(we_n),
        .store_busy_n_i(bsy), .store_busy_n_o(bsy_o),
        .store_busy_n_oe_n_o(bsy_oe_n));
    nvsc_dev_model u_dev (
        .clk_i(clk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .addr_i(addr), .bus_i(dq_bus), .busy_n_i(bsy), .busy_pull_o(pull),
        .dq_o(dq_dev), .store_cnt_o(st_cnt), .viol_o(viol));
    // ----------------------------------------
    // clock, watchdog and shared tasks
    // ----------------------------------------
    always #50 clk = ~clk;
    // a run needs well under a thousand cycles; this cuts off a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic wait_on(input bit want_rsp);
        int n;
        n = 0;
        while ((want_rsp ? rsp : rdy) !== 1'h1 && n < 600) begin
            @(posedge clk);
            #DLY;
            n++;
        end
        cmp({31'h0, n < 600}, 32'h1, "handshake stalled");
    endtask
    // one request; valid held until the edge that sees ready high
    task automatic xfer(input nvsc_pkg::nvsc_op_type op,
                        input logic [14:0] a, input logic [7:0] d);
        wait_on(1'b0);
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'h1;
        @(posedge clk);
        #DLY;
        req_valid = 1'h0;
        wait_on(1'b1);
        rdata = rsp_data;
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        xfer(nvsc_pkg::OP_READ, a, 8'h00);
        cmp({24'h0, rdata}, {24'h0, e}, "read byte");
    endtask
    task automatic hw_store();
        wait_on(1'b0);
        hw_req = 1'h1;
        for (int n = 0; n < 100 && bsy !== 1'h0; n++) @(posedge clk);
        #DLY;
        cmp({31'h0, rdy}, 32'h0, "ready while busy low");
        @(posedge clk);
        #DLY;
        cmp({31'h0, bsy_seen}, 32'h0, "busy status missed");
        hw_req = 1'h0;
        wait_on(1'b0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_rw();
        logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h4ABC, 15'h0ABC};
        for (int i = 0; i < 4; i++) xfer(nvsc_pkg::OP_WRITE, a[i],
            8'(8'h11 * (i + 1)));
        for (int i = 0; i < 4; i++) rd(a[i], 8'(8'h11 * (i + 1)));
    endtask
    task automatic t_sw();
        int s0;
        s0 = st_cnt;
        xfer(nvsc_pkg::OP_WRITE, 15'h0100, 8'hA5);
        xfer(nvsc_pkg::OP_STORE, 15'h0000, 8'h00);
        xfer(nvsc_pkg::OP_STORE, 15'h0000, 8'h00);
        cmp(st_cnt, s0 + 2, "software stores");
        xfer(nvsc_pkg::OP_WRITE, 15'h0100, 8'h3C);
        rd(15'h0100, 8'h3C);
        xfer(nvsc_pkg::OP_RECALL, 15'h0000, 8'h00);
        rd(15'h0100, 8'hA5);
        xfer(nvsc_pkg::OP_RECALL, 15'h0000, 8'h00);
        rd(15'h0100, 8'hA5);
        cmp(st_cnt, s0 + 2, "recall caused a store");
    endtask
    task automatic t_hw();
        int s0;
        s0 = st_cnt;
        hw_store();
        cmp(st_cnt, s0, "store without a write");
        xfer(nvsc_pkg::OP_WRITE, 15'h0200, 8'h77);
        hw_store();
        cmp(st_cnt, s0 + 1, "pin store missing");
        xfer(nvsc_pkg::OP_WRITE, 15'h0200, 8'h00);
        xfer(nvsc_pkg::OP_RECALL, 15'h0000, 8'h00);
        rd(15'h0200, 8'h77);
    endtask
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        req_valid = 1'h0;
        hw_req = 1'h0;
        req_op = nvsc_pkg::OP_READ;
        req_addr = 15'h0000;
        req_wdata = 8'h00;
        repeat (10) @(posedge clk);
        #DLY;
        rst_n = 1'h1;
        rd(15'h0123, 8'h23 ^ 8'h5A);
        t_rw();
        t_sw();
        t_hw();
        cmp(viol, 0, "host broke a bus timing");
        tally_and_finish();
    end
endmodule // nvsc_host_tb
`default_nettype wire
